// >>> dhm_top.v
`timescale 1ns/100ps
`include "dhm_defs.vh"

// Dual halfword multiply-accumulate datapath, APB slave
module dhm_top (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire        irq
);

    // Sequencer states
    // Waiting for a start write
    localparam S_IDLE = 1'b0;
    // Products in flight, datapath writes refused
    localparam S_MUL  = 1'b1;

    // Control fields kept from last idle control write
    reg [`DHM_CTRL_W-1:0] ctrl_r;
    // First operand register
    reg [31:0] opa_r;
    // Second operand register
    reg [31:0] opb_r;
    // Accumulate source register
    reg [31:0] acc_r;
    // Long accumulator low and high words
    reg [31:0] rlo_r;
    reg [31:0] rhi_r;
    // Destination of 32-bit operations
    reg [31:0] dest_r;
    // Program status word
    reg [31:0] psw_r;
    // Sticky interrupt status and mask
    reg [`DHM_IW-1:0] istat_r;
    reg [`DHM_IW-1:0] imask_r;
    // Sequencer state
    reg        state_r;
    // Pulse into the product unit
    reg        mstart_r;

    // Next values
    // Long result pair
    reg [31:0] rlo_nxt;
    reg [31:0] rhi_nxt;
    // 32-bit result, flags and interrupts
    reg [31:0] dest_nxt;
    reg [31:0] psw_nxt;
    reg [`DHM_IW-1:0] istat_nxt;

    // Product unit outputs
    // Low halfword product
    wire [31:0] p_lo;
    // High halfword product
    wire [31:0] p_hi;
    // Word by halfword product, top bits
    wire [31:0] p_w;
    // Products valid, one cycle pulse
    wire        mdone;

    // Decoded control fields
    wire [1:0] op_sel = ctrl_r[`DHM_C_OP_HI:`DHM_C_OP_LO];
    wire       cpass  = ctrl_r[`DHM_C_CPASS];
    wire       busy   = (state_r == S_MUL);

    // Bus phases
    // First cycle of a transfer
    wire setup  = psel & ~penable;
    // Second cycle, transfer completes here
    wire access = psel & penable;
    // Write lands at the end of access
    wire wr     = access & pwrite;

    // Address decode
    wire hit_ctrl  = (paddr == `DHM_A_CTRL);
    wire hit_opa   = (paddr == `DHM_A_OPA);
    wire hit_opb   = (paddr == `DHM_A_OPB);
    wire hit_acc   = (paddr == `DHM_A_ACC);
    wire hit_rlo   = (paddr == `DHM_A_RLO);
    wire hit_rhi   = (paddr == `DHM_A_RHI);
    wire hit_dest  = (paddr == `DHM_A_DEST);
    wire hit_psw   = (paddr == `DHM_A_PSW);
    wire hit_stat  = (paddr == `DHM_A_STAT);
    wire hit_istat = (paddr == `DHM_A_ISTAT);
    wire hit_imask = (paddr == `DHM_A_IMASK);
    // Any mapped register
    wire hit = hit_ctrl | hit_opa | hit_opb | hit_acc |
               hit_rlo | hit_rhi | hit_dest | hit_psw |
               hit_stat | hit_istat | hit_imask;

    // Datapath writes are refused while an operation runs
    wire wr_ok = wr & ~busy;
    // Start request, only from idle
    wire go = wr_ok & hit_ctrl & pwdata[`DHM_C_START];

    // Zero wait states; error on unmapped address
    assign pready  = 1'b1;
    assign pslverr = access & ~hit;

    // Level interrupt from unmasked sticky bits
    // Mask and status share one layout
    assign irq = |(istat_r & imask_r);

    // Product unit
    dhm_mul u_mul (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (mstart_r),
        .xsel    (ctrl_r[`DHM_C_XSEL]),
        .opa     (opa_r),
        .opb     (opb_r),
        .p_lo_r  (p_lo),
        .p_hi_r  (p_hi),
        .p_w_r   (p_w),
        .done_r  (mdone)
    );

    // Pair read as one signed accumulator
    // 64-bit accumulate of both products
    wire [63:0] long_acc = {rhi_r, rlo_r};
    wire [63:0] long_sum = long_acc
                         + {{32{p_lo[31]}}, p_lo}
                         + {{32{p_hi[31]}}, p_hi};

    // word-half: high product bits plus accumulate
    wire [31:0] wh_sum = p_w + acc_r;
    wire wh_ovf = (p_w[31] == acc_r[31]) &
                  (wh_sum[31] != acc_r[31]);

    wire [31:0] diff    = p_lo - p_hi;
    wire [31:0] df_sum  = acc_r + diff;
    wire df_ovf = (diff[31] == acc_r[31]) &
                  (df_sum[31] != acc_r[31]);

    // Completion with condition passed
    // Failed condition still completes, writes nothing
    wire commit = mdone & busy & cpass;
    // Saturation event from either 32-bit operation
    reg  sat_evt;

    // Saturation event select
    always @* begin
        case (op_sel)
            `DHM_OP_WHALF: sat_evt = commit & wh_ovf;
            `DHM_OP_DIFF:  sat_evt = commit & df_ovf;
            default:       sat_evt = 1'b0;
        endcase
    end

    // Result register next values
    always @* begin
        rlo_nxt  = rlo_r;
        rhi_nxt  = rhi_r;
        dest_nxt = dest_r;
        // Software load of result registers when idle
        if (wr_ok & hit_rlo) begin
            rlo_nxt = pwdata;
        end
        if (wr_ok & hit_rhi) begin
            rhi_nxt = pwdata;
        end
        if (wr_ok & hit_dest) begin
            dest_nxt = pwdata;
        end
        if (commit) begin
            case (op_sel)
                // write back to the same pair
                `DHM_OP_LONG: begin
                    rlo_nxt = long_sum[31:0];
                    rhi_nxt = long_sum[63:32];
                end
                `DHM_OP_WHALF: begin
                    dest_nxt = wh_sum;
                end
                `DHM_OP_DIFF: begin
                    dest_nxt = df_sum;
                end
                // Unused code: no write
                default: begin
                    dest_nxt = dest_r;
                end
            endcase
        end
    end

    // Status word next value
    always @* begin
        psw_nxt = psw_r;
        // Software may load flags when idle
        if (wr_ok & hit_psw) begin
            psw_nxt = pwdata & `DHM_PSW_MASK;
        end
        // only Q is touched; N Z C V kept
        // set wins over write, never cleared here
        if (sat_evt) begin
            psw_nxt[`DHM_PSW_Q] = 1'b1;
        end
    end

    // Sticky interrupt status, write one to clear
    always @* begin
        istat_nxt = istat_r;
        // Ones written clear, even while busy
        if (wr & hit_istat) begin
            istat_nxt = istat_r & ~pwdata[`DHM_IW-1:0];
        end
        // Events win over a clear in the same cycle
        // Done on every completion, condition or not
        if (mdone & busy) begin
            istat_nxt[`DHM_I_DONE] = 1'b1;
        end
        // Saturation only on a committed overflow
        if (sat_evt) begin
            istat_nxt[`DHM_I_SAT] = 1'b1;
        end
    end

    // Software-loaded registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Everything cleared, mask closed
            ctrl_r  <= `DHM_CTRL_RST;
            opa_r   <= 32'h00000000;
            opb_r   <= 32'h00000000;
            acc_r   <= 32'h00000000;
            imask_r <= `DHM_I_RST;
        end else begin
            // Control fields latched on any idle control write
            if (wr_ok & hit_ctrl) begin
                ctrl_r <= pwdata[`DHM_CTRL_W-1:0];
            end
            // Operands frozen while busy
            if (wr_ok & hit_opa) begin
                opa_r <= pwdata;
            end
            // Second operand also sets the product length
            if (wr_ok & hit_opb) begin
                opb_r <= pwdata;
            end
            // Accumulate source of the 32-bit operations
            if (wr_ok & hit_acc) begin
                acc_r <= pwdata;
            end
            // Mask writable at any time
            if (wr & hit_imask) begin
                imask_r <= pwdata[`DHM_IW-1:0];
            end
        end
    end

    // Results, flags and interrupt status
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Results and flags cleared
            rlo_r   <= 32'h00000000;
            rhi_r   <= 32'h00000000;
            dest_r  <= 32'h00000000;
            psw_r   <= `DHM_PSW_RST;
            istat_r <= `DHM_I_RST;
        end else begin
            // Every cycle takes the next values
            rlo_r   <= rlo_nxt;
            rhi_r   <= rhi_nxt;
            dest_r  <= dest_nxt;
            psw_r   <= psw_nxt;
            istat_r <= istat_nxt;
        end
    end

    // Sequencer: start, wait for products, commit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Idle, no pulse pending
            state_r  <= S_IDLE;
            mstart_r <= 1'b0;
        end else begin
            // Start pulse lasts one cycle
            mstart_r <= 1'b0;
            case (state_r)
                // Wait for a start request
                S_IDLE: begin
                    if (go) begin
                        mstart_r <= 1'b1;
                        state_r  <= S_MUL;
                    end
                end
                S_MUL: begin
                    // Completion edge ends busy
                    if (mdone) begin
                        state_r <= S_IDLE;
                    end
                end
                // Stray code falls back to idle
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    // Read data captured in the setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Reads zero out of reset
            prdata <= 32'h00000000;
        // Loaded in setup, stands through access
        end else if (setup & ~pwrite) begin
            case (paddr)
                `DHM_A_CTRL:  prdata <= {27'h0000000, ctrl_r};
                `DHM_A_OPA:   prdata <= opa_r;
                `DHM_A_OPB:   prdata <= opb_r;
                `DHM_A_ACC:   prdata <= acc_r;
                `DHM_A_RLO:   prdata <= rlo_r;
                `DHM_A_RHI:   prdata <= rhi_r;
                `DHM_A_DEST:  prdata <= dest_r;
                `DHM_A_PSW:   prdata <= psw_r;
                `DHM_A_STAT:  prdata <= {31'h00000000, busy};
                `DHM_A_ISTAT: prdata <= {30'h00000000, istat_r};
                `DHM_A_IMASK: prdata <= {30'h00000000, imask_r};
                // Unmapped reads as zero
                default:      prdata <= 32'h00000000;
            endcase
        end
    end

endmodule // dhm_top

// >>> dhm_defs.vh
`ifndef DHM_DEFS_VH
`define DHM_DEFS_VH

// Register byte offsets
`define DHM_A_CTRL    8'h00
`define DHM_A_OPA     8'h04
`define DHM_A_OPB     8'h08
`define DHM_A_ACC     8'h0C
`define DHM_A_RLO     8'h10
`define DHM_A_RHI     8'h14
`define DHM_A_DEST    8'h18
`define DHM_A_PSW     8'h1C
`define DHM_A_STAT    8'h20
`define DHM_A_ISTAT   8'h24
`define DHM_A_IMASK   8'h28

// Control register fields
`define DHM_C_START   0
`define DHM_C_OP_LO   1
`define DHM_C_OP_HI   2
`define DHM_C_XSEL    3
`define DHM_C_CPASS   4
`define DHM_CTRL_W    5
`define DHM_CTRL_RST  5'h00

// Operation codes
`define DHM_OP_LONG   2'h0
`define DHM_OP_WHALF  2'h1
`define DHM_OP_DIFF   2'h2

// Status word: N Z C V in 31:28, sticky Q in 27
`define DHM_PSW_Q     27
`define DHM_PSW_MASK  32'hF8000000
`define DHM_PSW_RST   32'h00000000

// Interrupt bits
`define DHM_I_DONE    0
`define DHM_I_SAT     1
`define DHM_IW        2
`define DHM_I_RST     2'h0

// Halfword size for rotation and slicing
`define DHM_HALF      16
`define DHM_W_LO      16
`define DHM_W_HI      47

`endif

// >>> dhm_mul.v
`timescale 1ns/100ps
`include "dhm_defs.vh"

// Signed product unit with early termination
module dhm_mul (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        start,
    input  wire        xsel,
    input  wire [31:0] opa,
    input  wire [31:0] opb,
    output reg  [31:0] p_lo_r,
    output reg  [31:0] p_hi_r,
    output reg  [31:0] p_w_r,
    output reg         done_r
);

    // Second operand, halves swapped on exchange
    // rotate right sixteen
    wire [31:0] op2 = xsel ?
        {opb[`DHM_HALF-1:0], opb[31:`DHM_HALF]} : opb;

    wire [15:0] bhalf = xsel ? opb[31:`DHM_HALF]
                             : opb[`DHM_HALF-1:0];

    wire signed [31:0] prod_lo =
        $signed(opa[15:0]) * $signed(op2[15:0]);
    wire signed [31:0] prod_hi =
        $signed(opa[31:16]) * $signed(op2[31:16]);
    wire signed [47:0] prod_w = $signed(opa) * $signed(bhalf);

    // short form when second operand fits 16 bits
    wire short_b = (opb[31:15] == {17{opb[15]}});

    // Second cycle pending for long operands
    reg hold_r;

    // Product capture and completion timing
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p_lo_r <= 32'h00000000;
            p_hi_r <= 32'h00000000;
            p_w_r  <= 32'h00000000;
            done_r <= 1'b0;
            hold_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (hold_r) begin
                hold_r <= 1'b0;
                done_r <= 1'b1;
            end else if (start) begin
                p_lo_r <= prod_lo;
                p_hi_r <= prod_hi;
                p_w_r  <= prod_w[`DHM_W_HI:`DHM_W_LO];
                if (short_b) begin
                    done_r <= 1'b1;
                end else begin
                    hold_r <= 1'b1;
                end
            end
        end
    end

endmodule // dhm_mul

// >>> dhm_top_sva.sv
`timescale 1ns/100ps
// Port-level checks on the datapath block
module dhm_top_sva (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        irq
);
    // Access phase, start write, mask write
    wire acc_w = psel && penable;
    wire wc    = acc_w && pwrite && paddr == 8'h00 && pwdata[0];
    wire wm    = acc_w && pwrite && paddr == 8'h28;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_err_unmap: assert property (acc_w && paddr > 8'h28 |-> pslverr)
        else $error("no error on unmapped address");
    chk_err_mapped: assert property (acc_w && paddr <= 8'h28
        && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped address");
    chk_err_setup: assert property (psel && !penable |-> !pslverr)
        else $error("error in setup phase");
    chk_unmap_zero: assert property (acc_w && !pwrite && paddr > 8'h28
        |-> prdata == 32'h00000000)
        else $error("unmapped read not zero");
    chk_psw_spare: assert property (
        acc_w && !pwrite && paddr == 8'h1C |-> prdata[26:0] == 27'h0)
        else $error("status word spare bits set");
    chk_irq_rise: assert property (
        $rose(irq) |-> $past(wc, 3) || $past(wc, 4) || $past(wm, 1))
        else $error("interrupt rose without cause");
    chk_irq_fall: assert property ($fell(irq)
        |-> $past(acc_w && pwrite, 1))
        else $error("interrupt fell without write");
endmodule // dhm_top_sva

bind dhm_top dhm_top_sva u_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));

// >>> dhm_issuer.sv
`timescale 1ns/100ps
// Issuing side: bus master standing in for decoder and register file
module dhm_issuer (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    logic last_err; // Error of last transfer
    initial begin
        psel = 0;
        penable = 0;
        pwrite = 0;
        paddr = 8'h00;
        pwdata = 32'h00000000;
    end
    // operands are plain values, separate result words
    // One transfer, held until pready sampled high
    task xfer(input logic w, input logic [7:0] a, inout logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : ~d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        if (!w) d = prdata;
        last_err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
endmodule // dhm_issuer

// >>> dhm_top_test.sv
`timescale 1ns/100ps
// Self-checking bench for the datapath block
module dhm_top_test;
    logic        pclk = 0;
    logic        presetn = 0;
    logic        psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    int          miscompares = 0;
    int          tests_run = 0;
    dhm_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq));
    dhm_issuer u_iss (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    initial forever #50 pclk = ~pclk;
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        u_iss.xfer(1, a, d);
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d);
        u_iss.xfer(0, a, d);
    endtask
    // Load operands, issue, wait, compare every result
    task mac(input logic [1:0] op, input logic x, c,
             input logic [31:0] a, b, acc, lo, hi, psw);
        logic [31:0] b2, h, el, eh, ed, ep, v;
        logic signed [47:0] p;
        logic signed [31:0] r;
        logic s;
        int n;
        b2 = x ? {b[15:0], b[31:16]} : b;
        h = x ? b[31:16] : b[15:0];
        wr(8'h04, a);
        wr(8'h08, b);
        wr(8'h0C, acc);
        wr(8'h10, lo);
        wr(8'h14, hi);
        wr(8'h18, 32'h0BADF00D);
        wr(8'h1C, psw);
        wr(8'h24, 32'h00000003);
        wr(8'h00, {27'h0, c, x, op, 1'b1});
        n = 0;
        do begin rd(8'h20, v); n++; end while (v[0] !== 1'b0 && n < 20);
        chk("busy cleared", 0, {31'h0, v[0]});
        {eh, el, ed, ep} = {hi, lo, 32'h0BADF00D, psw};
        s = 0;
        if (c) case (op)
            2'h0: {eh, el} = $signed({hi, lo})
                + $signed(a[15:0]) * $signed(b2[15:0])
                + $signed(a[31:16]) * $signed(b2[31:16]);
            2'h1: begin
                p = $signed(a) * $signed(h[15:0]);
                ed = p[47:16] + acc;
                if (acc[31] == p[47] && ed[31] != acc[31]) begin
                    ep[27] = 1;
                    s = 1;
                end
            end
            2'h2: begin
                r = $signed(a[15:0]) * $signed(b2[15:0])
                    - $signed(a[31:16]) * $signed(b2[31:16]);
                ed = acc + r;
                if (acc[31] == r[31] && ed[31] != acc[31]) begin
                    ep[27] = 1;
                    s = 1;
                end
            end
            default: ;
        endcase
        rd(8'h10, v); chk("low result", el, v);
        rd(8'h14, v); chk("high result", eh, v);
        rd(8'h18, v); chk("destination", ed, v);
        rd(8'h1C, v); chk("status word", ep, v);
        rd(8'h24, v); chk("done flag", 1, {31'h0, v[0]});
        chk("saturation flag", {31'h0, s}, {31'h0, v[1]});
    endtask
    task t_map;
        logic [31:0] v;
        for (int i = 0; i <= 8'h28; i += 4) begin
            rd(i[7:0], v); chk("reset value", 0, v);
        end
        rd(8'h2C, v); chk("unmapped data", 0, v);
        chk("unmapped error", 1, {31'h0, u_iss.last_err});
        $display("test map done");
    endtask
    task t_long;
        mac(0, 0, 1, 32'h7FFF8000, 32'h80007FFF, 0, 32'hFFFFFFF0,
            32'h00000001, 32'hF8000000);
        mac(0, 1, 1, 32'h7FFF8000, 32'h00001234, 0, 32'hFFFFFFF0,
            32'h80000000, 32'h08000000);
        $display("test long done");
    endtask
    task t_whalf;
        mac(1, 0, 1, 32'h7FFFFFFF, 32'h00004000, 32'h7FFFFFFF, 0, 0,
            0);
        mac(1, 1, 1, 32'h00010000, 32'hFFFE0000, 5, 0, 0,
            32'hA8000000);
        $display("test word half done");
    endtask
    task t_diff;
        mac(2, 0, 1, 32'h80008000, 32'h7FFF8000, 32'h00010000, 0, 0,
            0);
        mac(2, 1, 1, 32'h00020003, 32'h00050007, 32'hFFFFFFFF, 0, 0,
            32'h50000000);
        $display("test diff done");
    endtask
    task t_cond;
        for (int o = 0; o < 3; o++)
            mac(o[1:0], 1, 0, 32'h7FFFFFFF, 32'h80008000, 32'h7FFFFFFF,
                1, 2, 32'h30000000);
        // Unused operation code: completes, writes nothing
        mac(3, 0, 1, 32'h7FFFFFFF, 32'h80008000, 32'h7FFFFFFF,
            1, 2, 32'h30000000);
        $display("test condition done");
    endtask
    task t_irq;
        wr(8'h28, 32'h00000001);
        @(negedge pclk);
        chk("irq masked in", 1, {31'h0, irq});
        wr(8'h24, 32'h00000001);
        @(negedge pclk);
        chk("irq cleared", 0, {31'h0, irq});
        mac(2, 0, 1, 1, 1, 0, 0, 0, 0);
        chk("irq after op", 1, {31'h0, irq});
        wr(8'h28, 32'h00000000);
        @(negedge pclk);
        chk("irq masked out", 0, {31'h0, irq});
        mac(1, 0, 1, 32'h7FFFFFFF, 32'h00004000, 32'h7FFFFFFF, 0, 0,
            0);
        wr(8'h28, 32'h00000002);
        @(negedge pclk);
        chk("irq on saturation", 1, {31'h0, irq});
        $display("test interrupt done");
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        t_map;
        t_long;
        t_whalf;
        t_diff;
        t_cond;
        t_irq;
        stop_test;
    end
    // Watchdog well beyond the expected run
    initial begin
        #2000000;
        miscompares++;
        stop_test;
    end
endmodule // dhm_top_test
